// file: core/spi_eeprom_slave_front_end.sv
// Purpose: serial slave front end: opcode decode, status register, hold, write protect
// Assumes: serial clock, select, data, hold, protect pins are asynchronous, sampled at 25 MHz
// Notes:   array data path is outside; array commands are only flagged
// Functional notes
// [R1] serial clock is only sampled as an input, never driven
// [R2] bytes shift msb first in and out
// [R3] first byte after select falls is the opcode
// [R4] bad opcode: ignore input, output floats, until next select fall
// [R5] deselected: input ignored, output floats
// [R6] hold keeps bit and byte position
// [R7] master lowers hold only while serial clock is low
// [R8] master raises hold while clock low; clock toggles during hold ignored
// [R9] during hold output floats and input ignored
// [R10] protect pin high imposes no restriction
// [R11] pin low with protect enable one refuses status writes
// [R12] pin falling during status write command aborts it
// [R13] pin change after internal write starts has no effect
// [R14] protect enable zero makes the pin ignored
// [R15] internal write lasts bounded time, busy shown throughout
// [R16] opcodes decode with bit 3 ignored
// [R17] status: enable bit7, protect bits 3:2, latch bit1, busy bit0
// [R18] busy: only read status accepted
module spi_eeprom_slave_front_end #(
  parameter int WRITE_CYCLE_CLKS = spi_front_pkg::WRITE_CYCLE_CLKS
) (
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic       sck_in,
  input  wire logic       csn_in,
  input  wire logic       si_in,
  input  wire logic       holdn_in,
  input  wire logic       wpn_in,
  output logic            so_out,
  output logic            so_oe_out,
  output logic [7:0]      status_out,
  output logic            busy_out,
  output logic            array_read_out,
  output logic            array_write_out,
  output logic            opcode_bad_out
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic sck_s;
  logic csn_s;
  logic si_s;
  logic holdn_s;
  logic wpn_s;

  sync2 #(.RST_VAL(1'b0)) u_sck  (.clk_in(clk_in), .rstn_in(rstn_in), .d_in(sck_in),
                                  .q_out(sck_s)); // R1
  sync2 #(.RST_VAL(1'b1)) u_csn  (.clk_in(clk_in), .rstn_in(rstn_in), .d_in(csn_in),
                                  .q_out(csn_s));
  sync2 #(.RST_VAL(1'b0)) u_si   (.clk_in(clk_in), .rstn_in(rstn_in), .d_in(si_in),
                                  .q_out(si_s));
  sync2 #(.RST_VAL(1'b1)) u_hold (.clk_in(clk_in), .rstn_in(rstn_in), .d_in(holdn_in),
                                  .q_out(holdn_s));
  sync2 #(.RST_VAL(1'b1)) u_wp   (.clk_in(clk_in), .rstn_in(rstn_in), .d_in(wpn_in),
                                  .q_out(wpn_s));

  // ------------------------------------------------------------
  // edge detection
  // ------------------------------------------------------------
  logic sck_q;
  logic csn_q;
  logic wpn_q;
  logic hold_q;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sck_q <= 1'b0;
      csn_q <= 1'b1;
      wpn_q <= 1'b1;
    end else begin
      sck_q <= sck_s;
      csn_q <= csn_s;
      wpn_q <= wpn_s;
    end
  end

  // hold changes only when the clock is low; clock edges during a pause are dropped
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hold_q <= 1'b0;
    end else if (csn_s) begin
      hold_q <= 1'b0;
    end else if (!sck_s) begin
      hold_q <= !holdn_s; // R7 R8
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic wp_fall;
  logic active;

  assign active   = !csn_s && !hold_q; // R5 R9
  assign sck_rise = sck_s && !sck_q && active; // R8
  assign sck_fall = !sck_s && sck_q && active;
  assign cs_fall  = !csn_s && csn_q;
  assign wp_fall  = !wpn_s && wpn_q;

  // ------------------------------------------------------------
  // shifter and phase
  // ------------------------------------------------------------
  spi_front_pkg::phase_t phase_q;
  logic [2:0] bit_q;
  logic [6:0] shin_q;
  logic [7:0] opc_q;
  logic [7:0] byte_in;
  logic       byte_done;

  assign byte_in   = {shin_q, si_s};
  assign byte_done = sck_rise && (bit_q == spi_front_pkg::BIT_LAST)
                     && (phase_q != spi_front_pkg::PH_DEAD);

  logic [7:0] opc_m;
  logic       opc_known;
  logic       is_read_status_cmd;
  logic       is_write_status_cmd;
  assign opc_m   = byte_in & spi_front_pkg::OPC_MASK; // R16
  assign opc_known = (opc_m == spi_front_pkg::SET_WRITE_ENABLE_CMD)
                  || (opc_m == spi_front_pkg::CLEAR_WRITE_ENABLE_CMD)
                  || (opc_m == spi_front_pkg::READ_STATUS_CMD)
                  || (opc_m == spi_front_pkg::WRITE_STATUS_CMD)
                  || (opc_m == spi_front_pkg::READ_ARRAY_CMD)
                  || (opc_m == spi_front_pkg::WRITE_ARRAY_CMD);
  assign is_read_status_cmd = (opc_q == spi_front_pkg::READ_STATUS_CMD);
  assign is_write_status_cmd = (opc_q == spi_front_pkg::WRITE_STATUS_CMD);

  logic busy_q;

  // bit counter and input shift, held while paused since edges are gated
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bit_q  <= 3'h0;
      shin_q <= 7'h00;
    end else if (cs_fall) begin
      bit_q  <= 3'h0;
    end else if (sck_rise && phase_q != spi_front_pkg::PH_DEAD) begin // R4
      bit_q  <= bit_q + 3'h1; // R6
      shin_q <= byte_in[6:0]; // R2
    end
  end

  // phase: first byte opcode, then data; bad opcode, or busy with any opcode but read status, goes dead
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      phase_q <= spi_front_pkg::PH_OPCODE;
      opc_q   <= 8'h00;
    end else if (cs_fall) begin
      phase_q <= spi_front_pkg::PH_OPCODE; // R3 R4
      opc_q   <= 8'h00;
    end else if (byte_done && phase_q == spi_front_pkg::PH_OPCODE) begin
      opc_q <= opc_m; // R3
      if (!opc_known || (busy_q && opc_m != spi_front_pkg::READ_STATUS_CMD)) begin
        phase_q <= spi_front_pkg::PH_DEAD; // R4 R18
      end else begin
        phase_q <= spi_front_pkg::PH_DATA;
      end
    end
  end

  // ------------------------------------------------------------
  // status register and write cycle
  // ------------------------------------------------------------
  logic       wel_q;
  logic [2:0] nv_q;      // enable, bp msb, bp lsb
  logic [7:0] wr_data_q;
  logic       wr_pend_q;
  logic       wr_abort_q;
  logic [22:0] wc_cnt_q;
  logic       hw_prot;

  assign hw_prot = !wpn_s && nv_q[2]; // R10 R11 R14

  // write status: capture data byte, fire on select rise
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_data_q  <= 8'h00;
      wr_pend_q  <= 1'b0;
      wr_abort_q <= 1'b0;
    end else if (cs_fall) begin
      wr_pend_q  <= 1'b0;
      wr_abort_q <= 1'b0;
    end else if (!csn_s) begin
      if (byte_done && phase_q == spi_front_pkg::PH_DATA && is_write_status_cmd && !wr_pend_q) begin
        wr_data_q <= byte_in;
        wr_pend_q <= 1'b1;
      end
      if (is_write_status_cmd && phase_q == spi_front_pkg::PH_DATA && wp_fall && nv_q[2]) begin
        wr_abort_q <= 1'b1; // R12
      end
    end else begin
      wr_pend_q <= 1'b0;
    end
  end

  logic wr_start;
  assign wr_start = csn_s && !csn_q && wr_pend_q && !wr_abort_q && wel_q && !hw_prot; // R11

  // self-timed cycle; protect pin no longer sampled once started
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_q   <= 1'b0;
      wc_cnt_q <= 23'h000000;
      nv_q     <= 3'h0;
    end else if (wr_start) begin
      busy_q   <= 1'b1; // R15
      wc_cnt_q <= 23'(WRITE_CYCLE_CLKS - 1);
    end else if (busy_q) begin
      if (wc_cnt_q == 23'h000000) begin
        busy_q <= 1'b0;
        nv_q   <= {wr_data_q[spi_front_pkg::ST_PROTECT_EN],
                   wr_data_q[spi_front_pkg::ST_BP_MSB],
                   wr_data_q[spi_front_pkg::ST_BP_LSB]}; // R13
      end else begin
        wc_cnt_q <= wc_cnt_q - 23'h000001;
      end
    end
  end

  // write enable latch: set and clear commands, cleared at end of write
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wel_q <= 1'b0;
    end else if (byte_done && phase_q == spi_front_pkg::PH_OPCODE && !busy_q) begin
      if (opc_m == spi_front_pkg::SET_WRITE_ENABLE_CMD) begin
        wel_q <= 1'b1;
      end else if (opc_m == spi_front_pkg::CLEAR_WRITE_ENABLE_CMD) begin
        wel_q <= 1'b0;
      end
    end else if (busy_q && wc_cnt_q == 23'h000000) begin
      wel_q <= 1'b0;
    end
  end

  logic [7:0] status;
  always_comb begin
    status = 8'h00;
    status[spi_front_pkg::ST_PROTECT_EN] = nv_q[2];
    status[spi_front_pkg::ST_BP_MSB]     = nv_q[1];
    status[spi_front_pkg::ST_BP_LSB]     = nv_q[0];
    status[spi_front_pkg::ST_WEL]        = wel_q;
    if (busy_q) begin
      status = spi_front_pkg::ST_ALL_ONES; // R17
    end
  end

  // ------------------------------------------------------------
  // serial output
  // ------------------------------------------------------------
  logic [7:0] shout_q;
  logic       drive_q;

  // load status on falling edge ending the opcode, shift msb first
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shout_q <= 8'h00;
      drive_q <= 1'b0;
    end else if (csn_s) begin
      drive_q <= 1'b0; // R5
    end else if (sck_fall) begin
      if (phase_q == spi_front_pkg::PH_DATA && is_read_status_cmd) begin
        if (bit_q == 3'h0) begin
          shout_q <= status; // R2
        end else begin
          shout_q <= {shout_q[6:0], 1'b0};
        end
        drive_q <= 1'b1;
      end else begin
        drive_q <= 1'b0; // R4
      end
    end
  end

  assign so_out    = shout_q[7];
  assign so_oe_out = drive_q && !hold_q && !csn_s
                     && phase_q != spi_front_pkg::PH_DEAD; // R9

  // ------------------------------------------------------------
  // status outputs
  // ------------------------------------------------------------
  logic arr_rd_q;
  logic arr_wr_q;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_out <= 8'h00;
      arr_rd_q   <= 1'b0;
      arr_wr_q   <= 1'b0;
    end else begin
      status_out <= status;
      arr_rd_q   <= phase_q == spi_front_pkg::PH_DATA
                    && opc_q == spi_front_pkg::READ_ARRAY_CMD;
      arr_wr_q   <= phase_q == spi_front_pkg::PH_DATA
                    && opc_q == spi_front_pkg::WRITE_ARRAY_CMD;
    end
  end
  assign busy_out        = busy_q;
  assign array_read_out  = arr_rd_q;
  assign array_write_out = arr_wr_q;
  assign opcode_bad_out  = phase_q == spi_front_pkg::PH_DEAD;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_wr_fire;
    wr_start;
  endsequence

  AST_DESELECT_FLOAT: assert property (@(posedge clk_in) disable iff (!rstn_in) // R5
    csn_s |-> !so_oe_out) else $error("output driven while deselected");
  AST_HOLD_FLOAT: assert property (@(posedge clk_in) disable iff (!rstn_in) // R9
    hold_q |-> !so_oe_out) else $error("output driven while paused");
  AST_DEAD_FLOAT: assert property (@(posedge clk_in) disable iff (!rstn_in) // R4
    phase_q == spi_front_pkg::PH_DEAD |-> !so_oe_out) else $error("output after bad opcode");
  AST_HOLD_KEEPS_POS: assert property (@(posedge clk_in) disable iff (!rstn_in) // R6
    (hold_q && !cs_fall) |=> $stable(bit_q)) else $error("position moved during pause");
  AST_BUSY_STATUS: assert property (@(posedge clk_in) disable iff (!rstn_in) // R17
    busy_q |-> status == spi_front_pkg::ST_ALL_ONES) else $error("busy status not all ones");
  AST_PROTECT_REFUSE: assert property (@(posedge clk_in) disable iff (!rstn_in) // R11
    (hw_prot && !busy_q) |=> !busy_q) else $error("status write while protected");
  AST_BUSY_HOLDS: assert property (@(posedge clk_in) disable iff (!rstn_in) // R15
    s_wr_fire |=> busy_q [*8]) else $error("busy dropped early");
  AST_BUSY_IGNORES: assert property (@(posedge clk_in) disable iff (!rstn_in) // R18
    (busy_q && byte_done && phase_q == spi_front_pkg::PH_OPCODE
     && opc_m != spi_front_pkg::READ_STATUS_CMD) |=> phase_q == spi_front_pkg::PH_DEAD)
    else $error("command accepted while busy");
  AST_OPCODE_BYTE: assert property (@(posedge clk_in) disable iff (!rstn_in) // R3
    cs_fall |=> phase_q == spi_front_pkg::PH_OPCODE && bit_q == 3'h0)
    else $error("select fall did not restart opcode");

endmodule

// file: core/spi_front_pkg.sv
// Purpose: shared constants for the serial eeprom slave front end
// Assumes: 25 MHz system clock, serial clock sampled as a plain input
// Notes:   opcode values ignore bit 3 when decoded
package spi_front_pkg;

  // ------------------------------------------------------------
  // opcodes (upper nibble zero, bit 3 ignored)
  // ------------------------------------------------------------
  localparam logic [7:0] OPC_MASK         = 8'hF7;
  localparam logic [7:0] SET_WRITE_ENABLE_CMD   = 8'h06;
  localparam logic [7:0] CLEAR_WRITE_ENABLE_CMD = 8'h04;
  localparam logic [7:0] READ_STATUS_CMD  = 8'h05;
  localparam logic [7:0] WRITE_STATUS_CMD = 8'h01;
  localparam logic [7:0] READ_ARRAY_CMD   = 8'h03;
  localparam logic [7:0] WRITE_ARRAY_CMD  = 8'h02;

  // ------------------------------------------------------------
  // status byte layout
  // ------------------------------------------------------------
  localparam int ST_PROTECT_EN = 7;
  localparam int ST_BP_MSB     = 3;
  localparam int ST_BP_LSB     = 2;
  localparam int ST_WEL        = 1;
  localparam int ST_BUSY       = 0;
  localparam logic [7:0] ST_ALL_ONES = 8'hFF;
  localparam logic [7:0] ST_WRITE_MASK = 8'h8C;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ              = 25_000_000;
  localparam int WRITE_CYCLE_TIME_MS = 5;
  localparam int WRITE_CYCLE_CLKS    = CLK_HZ / 1000 * WRITE_CYCLE_TIME_MS;

  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [1:0] {
    PH_OPCODE = 2'b00,
    PH_DATA   = 2'b01,
    PH_DEAD   = 2'b10
  } phase_t;

endpackage

// file: core/sync2.sv
// Purpose: two flip-flop synchroniser for one pin
// Assumes: asynchronous active low reset
// Notes:   first stage is read only by the second stage
module sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_q;

  // two stages, reset to the pin's idle level
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q <= RST_VAL;
      q_out  <= RST_VAL;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule

// file: dv/spi_eeprom_slave_front_end_tb_top.sv
// Purpose: self-checking bench for the serial eeprom slave front end
// Assumes: write cycle shortened to 400 system clocks
// Notes:   command frames built from model tasks, results compared to fixed values
module spi_eeprom_slave_front_end_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int WC_CLKS = 400;
  localparam int LIMIT   = 20000;

  logic       clk_in, rstn_in, sck, csn, si, holdn, wpn;
  logic       so, so_oe, busy, arr_rd, arr_wr, bad;
  logic [7:0] status, rx, oe;
  logic [2:0] flags;
  int         mismatches, comparisons, cycles, n;

  spi_eeprom_slave_front_end #(.WRITE_CYCLE_CLKS(WC_CLKS)) spi_eeprom_slave_front_end_i (
    .clk_in(clk_in), .rstn_in(rstn_in), .sck_in(sck), .csn_in(csn), .si_in(si),
    .holdn_in(holdn), .wpn_in(wpn), .so_out(so), .so_oe_out(so_oe),
    .status_out(status), .busy_out(busy), .array_read_out(arr_rd),
    .array_write_out(arr_wr), .opcode_bad_out(bad));

  spi_master_model spi_master_model_i (
    .clk_in(clk_in), .so_in(so), .so_oe_in(so_oe), .sck_out(sck), .csn_out(csn),
    .si_out(si), .holdn_out(holdn), .wpn_out(wpn));

  // ------------------------------------------------------------
  // clock, reset, hang guard
  // ------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // a hung handshake would otherwise run forever
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      close_out();
    end
  end

  // ------------------------------------------------------------
  // compare and command tasks
  // ------------------------------------------------------------
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_flag(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  // one frame; flags are taken while still selected, after the last fall lands
  task automatic cmd(input logic [7:0] op, input logic [7:0] dat, input int nb,
                     input int hold_at, input logic glitch);
    spi_master_model_i.sel(1'b0);
    spi_master_model_i.xfer(op, hold_at, rx, oe);
    if (glitch) begin
      spi_master_model_i.set_wpn(1'b0);
      spi_master_model_i.tick(8);
      spi_master_model_i.set_wpn(1'b1);
    end
    if (nb > 1) begin
      spi_master_model_i.xfer(dat, hold_at, rx, oe);
    end
    spi_master_model_i.tick(8);
    flags = {arr_rd, arr_wr, bad};
    spi_master_model_i.sel(1'b1);
  endtask

  task automatic rd_status(input logic [7:0] exp, input int hold_at);
    cmd(8'h05, 8'h00, 2, hold_at, 1'b0);
    chk_byte("status byte", exp, rx);
    chk_byte("status drive", 8'hFF, oe);
  endtask

  task automatic wait_busy(output int cnt);
    cnt = 0;
    while (busy === 1'b1 && cnt < 2000) begin
      @(posedge clk_in);
      cnt++;
    end
  endtask

  task automatic close_out();
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    rstn_in     = 1'b0;
    mismatches  = 0;
    comparisons = 0;
    cycles      = 0;
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    chk_byte("reset status", 8'h00, status);
    chk_flag("reset drive", 1'b0, so_oe);
    spi_master_model_i.xfer(8'h06, 8, rx, oe);
    chk_byte("deselected drive", 8'h00, oe);
    rd_status(8'h00, 8);
    cmd(8'h0E, 8'h00, 1, 8, 1'b0);
    rd_status(8'h02, 3);
    chk_flag("paused drive", 1'b0, spi_master_model_i.hold_oe);
    cmd(8'h0C, 8'h00, 1, 8, 1'b0);
    rd_status(8'h00, 8);
    // write with pin high; busy reads all ones and refuses other commands
    cmd(8'h06, 8'h00, 1, 8, 1'b0);
    cmd(8'h01, 8'hFE, 2, 8, 1'b0);
    chk_flag("busy after write", 1'b1, busy);
    rd_status(8'hFF, 8);
    cmd(8'h06, 8'h00, 1, 8, 1'b0);
    chk_flag("refused while busy", 1'b1, flags[0]);
    wait_busy(n);
    rd_status(8'h8C, 8);
    // pin low with protect enable set
    spi_master_model_i.set_wpn(1'b0);
    cmd(8'h06, 8'h00, 1, 8, 1'b0);
    cmd(8'h01, 8'h00, 2, 8, 1'b0);
    chk_flag("protected write", 1'b0, busy);
    cmd(8'h04, 8'h00, 1, 8, 1'b0);
    rd_status(8'h8C, 8);
    // pin dips during the write frame only
    spi_master_model_i.set_wpn(1'b1);
    cmd(8'h06, 8'h00, 1, 8, 1'b0);
    cmd(8'h01, 8'h00, 2, 8, 1'b1);
    chk_flag("aborted write", 1'b0, busy);
    cmd(8'h04, 8'h00, 1, 8, 1'b0);
    rd_status(8'h8C, 8);
    // pin falls after the internal write started
    cmd(8'h06, 8'h00, 1, 8, 1'b0);
    cmd(8'h01, 8'h0C, 2, 8, 1'b0);
    spi_master_model_i.set_wpn(1'b0);
    chk_flag("started write", 1'b1, busy);
    wait_busy(n);
    rd_status(8'h0C, 8);
    // protect enable clear: pin low is ignored
    cmd(8'h06, 8'h00, 1, 8, 1'b0);
    cmd(8'h01, 8'h04, 2, 8, 1'b0);
    wait_busy(n);
    chk_flag("write span", 1'b1, n >= WC_CLKS - 20 && n <= WC_CLKS);
    rd_status(8'h04, 8);
    // unknown opcode silences the frame until the next select fall
    cmd(8'hA5, 8'h05, 2, 8, 1'b0);
    chk_byte("bad frame drive", 8'h00, oe);
    chk_flag("bad opcode flag", 1'b1, flags[0]);
    rd_status(8'h04, 8);
    chk_flag("bad flag cleared", 1'b0, flags[0]);
    // array commands with bit 3 set
    cmd(8'h0B, 8'h00, 2, 8, 1'b0);
    chk_flag("array read", 1'b1, flags[2]);
    cmd(8'h06, 8'h00, 1, 8, 1'b0);
    cmd(8'h0A, 8'h00, 2, 8, 1'b0);
    chk_flag("array write", 1'b1, flags[1]);
    close_out();
  end
endmodule

// file: dv/spi_master_model.sv
// Purpose: serial master model that drives clock, select, data, pause and protect pins
// Assumes: mode 0, serial clock half period of 4 system clocks (320 ns period)
// Notes:   pins change only at system clock rising edges; clock stands low outside frames
module spi_master_model (
  input  wire logic clk_in,
  input  wire logic so_in,
  input  wire logic so_oe_in,
  output logic      sck_out,
  output logic      csn_out,
  output logic      si_out,
  output logic      holdn_out,
  output logic      wpn_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic hold_oe;

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  // idle pins: deselected, clock low, no pause, protect pin high
  initial begin
    sck_out   = 1'b0;
    csn_out   = 1'b1;
    si_out    = 1'b0;
    holdn_out = 1'b1;
    wpn_out   = 1'b1;
    hold_oe   = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // select change; data line flips so a stale bit never looks valid
  task automatic sel(input logic v);
    tick(1);
    csn_out <= v;
    si_out  <= ~si_out;
    tick(8);
  endtask

  task automatic set_wpn(input logic v);
    tick(1);
    wpn_out <= v;
  endtask

  // pause with clock low, wiggle clock and data meanwhile, resume with clock low
  task automatic pause();
    tick(4);
    holdn_out <= 1'b0;
    tick(4);
    repeat (4) begin
      sck_out <= ~sck_out;
      si_out  <= ~si_out;
      tick(4);
      hold_oe = hold_oe | so_oe_in;
    end
    holdn_out <= 1'b1;
    tick(4);
  endtask

  // one byte, msb first; output sampled late in the high half, well after it settles
  task automatic xfer(input logic [7:0] tx, input int hold_at, output logic [7:0] rx,
                      output logic [7:0] oe);
    for (int i = 7; i >= 0; i--) begin
      if (i == hold_at) begin
        pause();
      end
      si_out <= tx[i];
      tick(4);
      sck_out <= 1'b1;
      tick(4);
      rx[i] = so_in;
      oe[i] = so_oe_in;
      sck_out <= 1'b0;
    end
  endtask
endmodule
